// File: shared/serial_port_regs.svh
// constants of the serial control port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define ADDR_CONFIG 10'h000
`define ADDR_READSEL 10'h004
`define ADDR_UPDATE 10'h232
`define ADDR_LAST 10'h232
`define CONFIG_DEFAULT 8'h18
`define BIT_THREE_WIRE 0
`define BIT_LSB_FIRST 1
`define BIT_SOFT_RESET 2
`define BIT_UPDATE 0
`define BIT_READSEL 0
`define INSTR_BITS 16
`define ABORT_MIN_CYCLES 1
`define ABORT_MAX_CYCLES 8
`define SCLK_HALF_DIV 8
`endif

// File: shared/serial_port_pkg.sv
// types of the serial control port
package serial_port_pkg;
  typedef logic [9:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [1:0] length_code_t;
endpackage

// File: shared/serial_port_if.sv
// link between host controller and device port
`timescale 1ns/1ps
interface serial_port_if;
  logic sclk;
  logic cs_n;
  logic sdio_host_o;
  logic sdio_host_oe_n;
  logic sdio_dev_o;
  logic sdio_dev_oe_n;
  logic readback_out_line_o;
  logic readback_out_line_oe_n;
  wire sdio_level = !sdio_host_oe_n ? sdio_host_o :
    (!sdio_dev_oe_n ? sdio_dev_o : 1'b0);
  wire readback_out_line = !readback_out_line_oe_n ?
    readback_out_line_o : 1'b0;
  modport host (output sclk, output cs_n, output sdio_host_o,
    output sdio_host_oe_n, input sdio_level, input readback_out_line);
  modport device (input sclk, input cs_n, input sdio_level,
    output sdio_dev_o, output sdio_dev_oe_n,
    output readback_out_line_o, output readback_out_line_oe_n);
endinterface

// File: hw/serial_port_device.sv
// device end: serial control port with shadow and active registers
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module serial_port_device
#(
  parameter int NUM_REGS = 563
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  serial_port_if.device link,
  input wire serial_port_pkg::reg_addr_t active_addr,
  output serial_port_pkg::reg_byte_t active_data,
  output logic busy
);
  import serial_port_pkg::*;
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } state_t;
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [1:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] sdio_s;
  logic sclk_d;
  logic cs_d;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_s <= 2'h0;
      cs_s <= 2'h3;
      sdio_s <= 2'h0;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      sclk_s <= {sclk_s[0], link.sclk};
      cs_s <= {cs_s[0], link.cs_n};
      sdio_s <= {sdio_s[0], link.sdio_level};
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end
  wire sclk_rise = sclk_s[1] & ~sclk_d;
  wire sclk_fall = ~sclk_s[1] & sclk_d;
  wire cs_low = ~cs_s[1];
  wire cs_rise = cs_s[1] & ~cs_d;
  wire cs_fall = ~cs_s[1] & cs_d;
  // ****************************************
  // register storage
  // ****************************************
  reg_byte_t shadow [NUM_REGS];
  reg_byte_t active [NUM_REGS];
  function automatic reg_byte_t reg_default(input int idx);
    reg_default = (idx == 0) ? `CONFIG_DEFAULT : 8'h00;
  endfunction
  function automatic logic in_map(input reg_addr_t a);
    in_map = (a <= `ADDR_LAST);
  endfunction
  // ****************************************
  // serial engine
  // ****************************************
  state_t state;
  logic [15:0] instr;
  logic [4:0] bit_cnt;
  logic [2:0] low_cnt;
  logic stalled;
  logic is_read;
  length_code_t length_code;
  reg_addr_t addr;
  logic [1:0] bytes_done;
  reg_byte_t shift;
  logic write_pulse;
  reg_addr_t write_addr;
  reg_byte_t write_byte;
  logic sdo_bit;
  logic drive;
  wire three_wire_select = active[0][`BIT_THREE_WIRE];
  // lsb-first takes effect from the shadow copy immediately
  wire lsb_first = shadow[0][`BIT_LSB_FIRST];
  wire soft_reset = shadow[0][`BIT_SOFT_RESET];
  wire read_active = shadow[4][`BIT_READSEL];
  wire reg_byte_t rd_byte = !in_map(addr) ? 8'h00 :
    (read_active ? active[addr] : shadow[addr]);
  wire [15:0] instr_next = lsb_first ? {sdio_s[1], instr[15:1]} :
    {instr[14:0], sdio_s[1]};
  wire reg_byte_t byte_next = lsb_first ? {sdio_s[1], shift[7:1]} :
    {shift[6:0], sdio_s[1]};
  wire last_fixed = (length_code != 2'h3) && (bytes_done == length_code);
  wire at_end = (addr == `ADDR_LAST) && (length_code == 2'h3);
  wire reg_addr_t addr_step = lsb_first ? addr + 10'h001 :
    (addr == 10'h000 ? `ADDR_LAST : addr - 10'h001);
  // instruction has a byte boundary after bit 8 as well
  wire byte_edge = (bit_cnt[2:0] == 3'h0);
  wire stream_data = (state == ST_DATA) && (length_code == 2'h3);
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      instr <= 16'h0000;
      bit_cnt <= 5'h00;
      low_cnt <= 3'h0;
      stalled <= 1'b0;
      is_read <= 1'b0;
      length_code <= 2'h0;
      addr <= 10'h000;
      bytes_done <= 2'h0;
      shift <= 8'h00;
      write_pulse <= 1'b0;
      write_addr <= 10'h000;
      write_byte <= 8'h00;
      sdo_bit <= 1'b0;
      drive <= 1'b0;
    end
    else
    begin
      write_pulse <= 1'b0;
      if (cs_fall)
        low_cnt <= 3'h0;
      else if (cs_low && sclk_rise && low_cnt != 3'h7)
        low_cnt <= low_cnt + 3'h1;
      if (cs_rise)
      begin
        drive <= 1'b0;
        if (!byte_edge || state == ST_DONE || stream_data)
        begin
          state <= ST_IDLE;
          stalled <= 1'b0;
          bit_cnt <= 5'h00;
        end
        else if (state != ST_IDLE)
        begin
          // select-low pulse with 1 to 6 sclk rises during stall counts as an abort
          if (stalled && low_cnt >= 3'(`ABORT_MIN_CYCLES) &&
              low_cnt < 3'(`ABORT_MAX_CYCLES - 1))
          begin
            state <= ST_IDLE;
            stalled <= 1'b0;
            bit_cnt <= 5'h00;
          end
          else
            stalled <= 1'b1;
        end
      end
      else if (cs_fall && state == ST_IDLE)
      begin
        state <= ST_INSTR;
        bit_cnt <= 5'h00;
      end
      else if (cs_low && sclk_rise)
      begin
        case (state)
          ST_INSTR:
          begin
            instr <= instr_next;
            bit_cnt <= (bit_cnt == 5'd15) ? 5'h00 : bit_cnt + 5'h01;
            if (bit_cnt == 5'(`INSTR_BITS - 1))
            begin
              is_read <= instr_next[15];
              length_code <= instr_next[14:13];
              addr <= instr_next[9:0];
              bytes_done <= 2'h0;
              state <= ST_DATA;
            end
          end
          ST_DATA:
          begin
            shift <= byte_next;
            bit_cnt <= (bit_cnt == 5'd7) ? 5'h00 : bit_cnt + 5'h01;
            if (bit_cnt == 5'd7)
            begin
              if (!is_read)
              begin
                write_pulse <= in_map(addr);
                write_addr <= addr;
                write_byte <= byte_next;
              end
              addr <= addr_step;
              bytes_done <= bytes_done + 2'h1;
              if (last_fixed || at_end)
                state <= ST_DONE;
            end
          end
          default:
            ;
        endcase
      end
      else if (cs_low && sclk_fall && state == ST_DATA && is_read)
      begin
        // launch next readback bit on falling edge
        sdo_bit <= lsb_first ? rd_byte[bit_cnt[2:0]] :
          rd_byte[3'h7 - bit_cnt[2:0]];
        drive <= 1'b1;
      end
      else if (!cs_low)
        drive <= 1'b0;
    end
  end
  // ****************************************
  // shadow and active update
  // ****************************************
  wire update_hit = write_pulse && write_addr == `ADDR_UPDATE &&
    write_byte[`BIT_UPDATE];
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        shadow[i] <= reg_default(i);
        active[i] <= reg_default(i);
      end
    end
    else if (soft_reset && !(write_pulse && write_addr == `ADDR_CONFIG))
    begin
      for (int i = 1; i < NUM_REGS; i++)
      begin
        shadow[i] <= reg_default(i);
        active[i] <= reg_default(i);
      end
      active[0] <= shadow[0];
    end
    else
    begin
      if (write_pulse)
        shadow[write_addr] <= write_byte;
      if (update_hit)
      begin
        for (int i = 0; i < NUM_REGS; i++)
          active[i] <= (10'(i) == write_addr) ? 8'h00 : shadow[i];
        shadow[`ADDR_UPDATE] <= 8'h00;
      end
      // config byte acts at once, independent of update
      if (write_pulse && write_addr == `ADDR_CONFIG)
        active[0] <= write_byte;
    end
  end
  // ****************************************
  // pin drivers
  // ****************************************
  logic [7:0] active_q;
  logic sdio_o;
  logic sdio_oe_n;
  logic rb_o;
  logic rb_oe_n;
  logic busy_q;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      active_q <= 8'h00;
      sdio_o <= 1'b0;
      sdio_oe_n <= 1'b1;
      rb_o <= 1'b0;
      rb_oe_n <= 1'b1;
      busy_q <= 1'b0;
    end
    else
    begin
      active_q <= in_map(active_addr) ? active[active_addr] : 8'h00;
      sdio_o <= sdo_bit;
      rb_o <= sdo_bit;
      sdio_oe_n <= !(drive && cs_low && !three_wire_select);
      rb_oe_n <= !(drive && cs_low && three_wire_select);
      busy_q <= (state != ST_IDLE);
    end
  end
  assign active_data = active_q;
  assign busy = busy_q;
  assign link.sdio_dev_o = sdio_o;
  assign link.sdio_dev_oe_n = sdio_oe_n;
  assign link.readback_out_line_o = rb_o;
  assign link.readback_out_line_oe_n = rb_oe_n;
endmodule

// File: hw/serial_port_host.sv
// host end: serial master driven by a small register port
`timescale 1ns/1ps
`include "serial_port_regs.svh"
module serial_port_host
(
  input wire logic mclk,
  input wire logic sys_rst,
  serial_port_if.host link,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  import serial_port_pkg::*;
  // ****************************************
  // command registers: 0 instr hi, 1 instr lo, 2 data, 3 ctrl/status
  // ****************************************
  logic [15:0] instr;
  logic [7:0] tx;
  logic [7:0] rx;
  logic use_rb_line;
  logic lsb;
  logic busy;
  logic [1:0] rb_s;
  logic [1:0] sd_s;
  logic [4:0] bit_cnt;
  logic [2:0] div;
  logic [23:0] sh;
  logic sclk_o;
  logic cs_o;
  logic dout;
  logic oe_n;
  logic [7:0] rdata_r;
  wire rx_bit = use_rb_line ? rb_s[1] : sd_s[1];
  wire [7:0] status = {5'h00, lsb, use_rb_line, busy};
  // first bit goes out with the select edge, before the first rise
  wire [23:0] load_sh = wdata[0] ?
    (wdata[2] ? {tx, instr} : {instr, tx}) :
    (wdata[2] ? {16'h0000, tx} : {tx, 16'h0000});
  wire first_bit = wdata[2] ? load_sh[0] : load_sh[23];
  wire [23:0] rest_sh = wdata[2] ? {1'b0, load_sh[23:1]} :
    {load_sh[22:0], 1'b0};
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      instr <= 16'h0000;
      tx <= 8'h00;
      rx <= 8'h00;
      use_rb_line <= 1'b0;
      lsb <= 1'b0;
      busy <= 1'b0;
      rb_s <= 2'h0;
      sd_s <= 2'h0;
      bit_cnt <= 5'h00;
      div <= 3'h0;
      sh <= 24'h000000;
      sclk_o <= 1'b0;
      cs_o <= 1'b1;
      dout <= 1'b0;
      oe_n <= 1'b1;
      rdata_r <= 8'h00;
    end
    else
    begin
      rb_s <= {rb_s[0], link.readback_out_line};
      sd_s <= {sd_s[0], link.sdio_level};
      rdata_r <= !rd ? 8'h00 : (addr == 3'h0 ? instr[15:8] :
        addr == 3'h1 ? instr[7:0] : addr == 3'h2 ? rx : status);
      if (wr && addr == 3'h0)
        instr[15:8] <= wdata;
      if (wr && addr == 3'h1)
        instr[7:0] <= wdata;
      if (wr && addr == 3'h2)
        tx <= wdata;
      if (wr && addr == 3'h3)
      begin
        use_rb_line <= wdata[1];
        lsb <= wdata[2];
        // bit0 sends instr+byte, bit3 sends one more byte, bit4 ends
        if (!busy && (wdata[0] || wdata[3]))
        begin
          busy <= 1'b1;
          sh <= rest_sh;
          dout <= first_bit;
          // a read continuation leaves the data line to the device
          oe_n <= !wdata[0] && instr[15];
          bit_cnt <= wdata[0] ? 5'd24 : 5'd8;
          cs_o <= 1'b0;
          div <= 3'h0;
        end
        if (!busy && wdata[4])
          cs_o <= 1'b1;
      end
      else if (busy)
      begin
        div <= (div == 3'(`SCLK_HALF_DIV - 1)) ? 3'h0 : div + 3'h1;
        if (div == 3'(`SCLK_HALF_DIV - 1))
        begin
          sclk_o <= ~sclk_o;
          if (!sclk_o)
          begin
            rx <= lsb ? {rx_bit, rx[7:1]} : {rx[6:0], rx_bit};
            bit_cnt <= bit_cnt - 5'h01;
          end
          else if (bit_cnt == 5'h00)
          begin
            busy <= 1'b0;
            oe_n <= 1'b1;
          end
          else
          begin
            dout <= lsb ? sh[0] : sh[23];
            sh <= lsb ? {1'b0, sh[23:1]} : {sh[22:0], 1'b0};
            oe_n <= (bit_cnt <= 5'd8) && instr[15] ? 1'b1 : 1'b0;
          end
        end
      end
    end
  end
  assign link.sclk = sclk_o;
  assign link.cs_n = cs_o;
  assign link.sdio_host_o = dout;
  assign link.sdio_host_oe_n = oe_n;
  assign rdata = rdata_r;
endmodule

// File: verif/serial_port_asserts.sv
// assertions on the link between host and device ends
`timescale 1ns/1ps
module serial_port_asserts
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_host_o,
  input wire logic sdio_host_oe_n,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe_n,
  input wire logic readback_out_line_o,
  input wire logic readback_out_line_oe_n
);
  // ****************************************
  // sclk rises seen since select fell
  // ****************************************
  logic sclk_q;
  logic [15:0] rises;
  wire logic dev_drives = !sdio_dev_oe_n || !readback_out_line_oe_n;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_q <= 1'b0;
      rises <= 16'h0000;
    end
    else
    begin
      sclk_q <= sclk;
      rises <= cs_n ? 16'h0000 : rises + 16'(sclk && !sclk_q);
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence high_phase;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence idle_run;
    cs_n [*6];
  endsequence
  hiz_idle_a: assert property (
    idle_run |-> sdio_dev_oe_n && readback_out_line_oe_n)
    else $error("device drives while deselected");
  one_pin_a: assert property (
    !(!sdio_dev_oe_n && !readback_out_line_oe_n))
    else $error("readback on both pins");
  no_fight_a: assert property (
    !(!sdio_host_oe_n && !sdio_dev_oe_n))
    else $error("both ends drive data line");
  dev_launch_a: assert property (
    !sdio_dev_oe_n && $changed(sdio_dev_o) |-> !sclk)
    else $error("readback changed while sclk high");
  rb_launch_a: assert property (
    !readback_out_line_oe_n && $changed(readback_out_line_o) |-> !sclk)
    else $error("readback line changed while sclk high");
  host_setup_a: assert property (
    !sdio_host_oe_n && $changed(sdio_host_o) |-> !sclk)
    else $error("host data changed while sclk high");
  sclk_phase_a: assert property (
    $rose(sclk) |-> high_phase)
    else $error("sclk high phase wrong");
  stall_low_a: assert property (
    cs_n |-> !sclk)
    else $error("sclk moves while deselected");
  instr_first_a: assert property (
    dev_drives && !cs_n |-> rises >= 16'd16)
    else $error("readback before instruction done");
endmodule

// File: verif/serial_control_port_bench.sv
// self-checking bench of both serial port ends
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module serial_control_port_bench;
  import serial_port_pkg::*;
  logic mclk, sys_rst, wr, rd, busy;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, mode, s;
  reg_addr_t active_addr;
  reg_byte_t active_data;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  serial_port_if link();
  serial_port_device serial_port_device_inst (.mclk(mclk),
    .sys_rst(sys_rst), .link(link), .active_addr(active_addr),
    .active_data(active_data), .busy(busy));
  serial_port_host serial_port_host_inst (.mclk(mclk), .sys_rst(sys_rst),
    .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  serial_port_asserts serial_port_asserts_inst (.mclk(mclk),
    .sys_rst(sys_rst), .sclk(link.sclk), .cs_n(link.cs_n),
    .sdio_host_o(link.sdio_host_o), .sdio_host_oe_n(link.sdio_host_oe_n),
    .sdio_dev_o(link.sdio_dev_o), .sdio_dev_oe_n(link.sdio_dev_oe_n),
    .readback_out_line_o(link.readback_out_line_o),
    .readback_out_line_oe_n(link.readback_out_line_oe_n));
  // ****************************************
  // register port and link tasks
  // ****************************************
  task summarize;
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task go(input logic [7:0] c);
    logic [7:0] st;
    wreg(3'h3, c | mode);
    repeat (8) @(posedge mclk);
    do
      rreg(3'h3, st);
    while (st[0] !== 1'b0);
  endtask
  task xfer(input logic [15:0] ins, input logic [31:0] d, input int n,
    input bit stall, output logic [7:0] got);
    wreg(3'h0, ins[15:8]);
    wreg(3'h1, ins[7:0]);
    wreg(3'h2, d[31:24]);
    go(8'h01);
    for (int k = 1; k < n; k++)
    begin
      if (stall)
        go(8'h10);
      wreg(3'h2, d[31-8*k -: 8]);
      go(8'h08);
    end
    rreg(3'h2, got);
    go(8'h10);
    while (busy !== 1'b0)
      @(posedge mclk);
  endtask
  task act(input reg_addr_t a, input reg_byte_t e);
    @(posedge mclk);
    active_addr <= a;
    @(posedge mclk);
    #1;
    `CHK(active_data, e)
  endtask
  // ****************************************
  // clock, timeout and test sequence
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      summarize;
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    active_addr = 10'h000;
    mode = 8'h00;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    act(10'h000, 8'h18);
    act(10'h004, 8'h00);
    xfer(16'h0004, 32'h01000000, 1, 0, s);
    act(10'h004, 8'h00);
    xfer(16'h0232, 32'h01000000, 1, 0, s);
    act(10'h004, 8'h01);
    act(10'h232, 8'h00);
    xfer(16'h2011, 32'hA53C0000, 2, 1, s);
    xfer(16'h4022, 32'h11223300, 3, 1, s);
    xfer(16'h6001, 32'h77180199, 4, 0, s);
    act(10'h011, 8'hA5);
    act(10'h010, 8'h3C);
    act(10'h020, 8'h33);
    act(10'h001, 8'h77);
    xfer(16'h0011, 32'h42000000, 1, 0, s);
    xfer(16'h8011, 32'h00000000, 1, 0, s);
    `CHK(s, 8'hA5)
    xfer(16'h0004, 32'h00000000, 1, 0, s);
    xfer(16'h0232, 32'h01000000, 1, 0, s);
    xfer(16'h0011, 32'h5C000000, 1, 0, s);
    xfer(16'h8011, 32'h00000000, 1, 0, s);
    `CHK(s, 8'h5C)
    xfer(16'h0000, 32'h99000000, 1, 0, s);
    act(10'h000, 8'h99);
    mode = 8'h02;
    xfer(16'hA011, 32'h00000000, 2, 0, s);
    `CHK(s, 8'h3C)
    xfer(16'h0000, 32'hBD000000, 1, 0, s);
    xfer(16'h0000, 32'h99000000, 1, 0, s);
    act(10'h011, 8'h00);
    act(10'h010, 8'h00);
    xfer(16'h0000, 32'hDB000000, 1, 0, s);
    mode = 8'h06;
    xfer(16'h2030, 32'h5A6B0000, 2, 0, s);
    xfer(16'hA030, 32'h00000000, 2, 0, s);
    `CHK(s, 8'h6B)
    summarize;
  end
endmodule
